/* File: rtl/spc_pkg.sv */
// Purpose: Shared constants, types and helpers for the serial port control block.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: None.
package spc_pkg;
    localparam logic [7:0] CTRL_INDEX = 8'h11;
    localparam logic [7:0] BUF_INDEX = 8'h13;
    localparam logic [7:0] STAT_INDEX = 8'h14;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int WRITE_COLLISION_FLAG_BIT = 7;
    localparam int OVF_BIT = 6;
    localparam int EN_BIT = 5;
    localparam int CKP_BIT = 4;
    localparam int MODE_LSB = 0;
    localparam logic [5:0] HALF_FOSC4 = 6'h02;
    localparam logic [5:0] HALF_FOSC16 = 6'h08;
    localparam logic [5:0] HALF_FOSC64 = 6'h20;
    localparam logic [2:0] PIN_SYNC_RESET = 3'h4;

    typedef enum logic [3:0] {
        SPC_SPI_M4 = 4'h0,
        SPC_SPI_M16 = 4'h1,
        SPC_SPI_M64 = 4'h2,
        SPC_SPI_MTMR = 4'h3,
        SPC_SPI_SSEL = 4'h4,
        SPC_SPI_SFREE = 4'h5,
        SPC_I2C_S7 = 4'h6,
        SPC_I2C_S10 = 4'h7,
        SPC_I2C_M = 4'h8
    } spc_mode_t;

    typedef enum logic [1:0] {
        SPC_IDLE = 2'b00,
        SPC_LEAD = 2'b01,
        SPC_TRAIL = 2'b10
    } spc_eng_state_t;

    function automatic logic spc_is_master(input logic [3:0] m);
        return m[3:2] == 2'b00;
    endfunction : spc_is_master

    function automatic logic spc_is_slave(input logic [3:0] m);
        return m == SPC_SPI_SSEL || m == SPC_SPI_SFREE;
    endfunction : spc_is_slave

    function automatic logic spc_is_i2c_slave(input logic [3:0] m);
        return m == SPC_I2C_S7 || m == SPC_I2C_S10;
    endfunction : spc_is_i2c_slave

    function automatic logic [7:0] spc_addr(input logic [7:0] index);
        return {index[5:0], 2'b00};
    endfunction : spc_addr
endpackage : spc_pkg

/* File: rtl/spc_link_if.sv */
// Purpose: Carries control and data between the register side and the shift engine.
// Assumes: Pin levels arrive already synchronised.
// Notes: None.
`timescale 1ns/100ps
`default_nettype none
interface spc_link_if;
    logic start;
    logic load;
    logic [7:0] tx_byte;
    logic [3:0] mode;
    logic en;
    logic clock_polarity_select;
    logic tick;
    logic sck_in;
    logic sdi_in;
    logic ss_n_in;
    logic busy;
    logic done;
    logic [7:0] rx_byte;
    logic sck_out;
    logic sdo_out;

    modport ctl (
        output start, load, tx_byte, mode, en, clock_polarity_select, tick, sck_in, sdi_in, ss_n_in,
        input busy, done, rx_byte, sck_out, sdo_out
    );
    modport eng (
        input start, load, tx_byte, mode, en, clock_polarity_select, tick, sck_in, sdi_in, ss_n_in,
        output busy, done, rx_byte, sck_out, sdo_out
    );
endinterface : spc_link_if
`default_nettype wire

/* File: rtl/spc_shift_engine.sv */
// Purpose: Eight-bit SPI shifter for master and slave operation.
// Assumes: Data changes on the trailing edge and is sampled on the leading edge.
// Notes: Master clock comes from a divider enable or the timer tick.
`timescale 1ns/100ps
`default_nettype none
module spc_shift_engine
    import spc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register side.
    spc_link_if.eng l
);
    spc_eng_state_t state;
    logic [7:0] sr;
    logic bit_in;
    logic [2:0] count;
    logic [5:0] div;
    logic [5:0] limit;
    logic sck_q;
    logic sck_prev;
    logic master;
    logic slave;
    logic selected;
    logic half_en;
    logic s_lead;
    logic s_trail;

    assign master = l.en && spc_is_master(l.mode);
    assign slave = l.en && spc_is_slave(l.mode);
    // Slave-select is honoured only in the mode that asks for it.
    assign selected = (l.mode == SPC_SPI_SSEL) ? !l.ss_n_in : 1'b1;
    assign limit = (l.mode == SPC_SPI_M4) ? HALF_FOSC4 :
                   (l.mode == SPC_SPI_M16) ? HALF_FOSC16 : HALF_FOSC64;
    assign half_en = (l.mode == SPC_SPI_MTMR) ? l.tick : (div == limit - 6'h01);
    assign s_lead = slave && selected && (l.sck_in != sck_prev) && (l.sck_in != l.clock_polarity_select);
    assign s_trail = slave && selected && (l.sck_in != sck_prev) && (l.sck_in == l.clock_polarity_select);
    assign l.busy = (state != SPC_IDLE) || (slave && count != 3'h0);
    assign l.sck_out = sck_q;
    assign l.sdo_out = sr[7];

    always_ff @(posedge clk)
    begin
        if (rst || state == SPC_IDLE || half_en)
            div <= 6'h00;
        else
            div <= div + 6'h01;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            sck_prev <= 1'b0;
        else
            sck_prev <= l.sck_in;
    end

    // Master sequencing; a transfer opens only on a buffer write.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= SPC_IDLE;
            sck_q <= 1'b0;
        end
        else
        begin
            case (state)
                SPC_IDLE:
                begin
                    sck_q <= l.clock_polarity_select;
                    if (l.start && master)
                        state <= SPC_LEAD;
                end
                SPC_LEAD:
                    if (half_en)
                    begin
                        sck_q <= !l.clock_polarity_select;
                        state <= SPC_TRAIL;
                    end
                SPC_TRAIL:
                    if (half_en)
                    begin
                        sck_q <= l.clock_polarity_select;
                        state <= (count == 3'h7) ? SPC_IDLE : SPC_LEAD;
                    end
                default:
                    state <= SPC_IDLE;
            endcase
        end
    end

    // Shift register and bit counter for both roles.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sr <= 8'h00;
            bit_in <= 1'b0;
            count <= 3'h0;
        end
        else if ((l.start && master) || l.load)
        begin
            sr <= l.tx_byte;
            count <= 3'h0;
        end
        else if (slave && !selected)
            count <= 3'h0;
        else if ((state == SPC_LEAD && half_en) || s_lead)
            bit_in <= l.sdi_in;
        else if ((state == SPC_TRAIL && half_en) || s_trail)
        begin
            sr <= {sr[6:0], bit_in};
            count <= count + 3'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            l.done <= 1'b0;
            l.rx_byte <= 8'h00;
        end
        else
        begin
            l.done <= 1'b0;
            if (count == 3'h7 && ((state == SPC_TRAIL && half_en) || s_trail))
            begin
                l.done <= 1'b1;
                l.rx_byte <= {sr[6:0], bit_in};
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_START_OPENS: assert property (l.start && master |=> state == SPC_LEAD)
        else $error("Master transfer did not open on buffer write.");
endmodule : spc_shift_engine
`default_nettype wire

/* File: rtl/spc_port_control.sv */
// Purpose: Control register and buffer access for the synchronous serial port.
// Assumes: APB slave; one wait-free access phase after each setup cycle.
// Notes: I2C sequencing sits outside and talks through the I2C ports.
`timescale 1ns/100ps
`default_nettype none
module spc_port_control
    import spc_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Serial pins.
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE,
    input wire logic SDI_I,
    output logic SDO_O,
    output logic SDO_OE,
    input wire logic SS_N_I,
    output logic SS_GPIO_FREE,
    output logic PINS_OWNED,
    // Timer tick for the timer-clocked master rate.
    input wire logic TMR_TICK,
    // I2C sequencer side.
    input wire logic I2C_BUS_IDLE,
    input wire logic I2C_RX_VALID,
    input wire logic [7:0] I2C_RX_DATA,
    output logic I2C_TX_START,
    output logic [7:0] I2C_TX_DATA,
    output logic SCL_HOLD_LOW
);
    import spc_pkg::*;

    spc_link_if l ();

    logic write_collision_flag;
    logic ovf;
    logic en;
    logic clock_polarity_select;
    logic [3:0] mode;
    logic [7:0] rx_hold;
    logic buf_full;
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [2:0] sy3;
    logic [2:0] filt;
    logic setup;
    logic wr;
    logic rd;
    logic hit_ctrl;
    logic hit_buf;
    logic hit_stat;
    logic spi_master;
    logic spi_slave;
    logic i2c_master;
    logic i2c_any;
    logic set_write_collision_flag;
    logic set_ovf;
    logic buf_clear;
    logic rx_event;
    logic [7:0] rx_data;
    logic [7:0] ctrl_value;

    assign setup = PSEL && !PENABLE;
    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && PENABLE && !PWRITE;
    assign hit_ctrl = PADDR == spc_addr(CTRL_INDEX);
    assign hit_buf = PADDR == spc_addr(BUF_INDEX);
    assign hit_stat = PADDR == spc_addr(STAT_INDEX);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !(hit_ctrl || hit_buf || hit_stat);

    assign spi_master = en && spc_is_master(mode);
    assign spi_slave = en && spc_is_slave(mode);
    assign i2c_master = en && mode == SPC_I2C_M;
    assign i2c_any = en && (spc_is_i2c_slave(mode) || mode == SPC_I2C_M);
    assign ctrl_value = {write_collision_flag, ovf, en, clock_polarity_select, mode};

    // Collision: I2C master needs an idle bus, SPI needs an idle shifter.
    assign set_write_collision_flag = wr && hit_buf && ((i2c_master && !I2C_BUS_IDLE) ||
                      ((spi_master || spi_slave) && l.busy));
    assign buf_clear = rd && hit_buf;
    assign rx_event = ((spi_master || spi_slave) && l.done) || (i2c_any && I2C_RX_VALID);
    assign rx_data = i2c_any ? I2C_RX_DATA : l.rx_byte;
    // Overflow only for slave SPI and every I2C mode, master included; an SPI master reception never flags it.
    assign set_ovf = rx_event && buf_full && !buf_clear && (spi_slave || i2c_any);

    // Pin inputs pass three flops; a level counts once stages two and three agree.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            sy1 <= PIN_SYNC_RESET;
            sy2 <= PIN_SYNC_RESET;
            sy3 <= PIN_SYNC_RESET;
            filt <= PIN_SYNC_RESET;
        end
        else
        begin
            sy1 <= {SS_N_I, SDI_I, SCK_I};
            sy2 <= sy1;
            sy3 <= sy2;
            filt <= (filt & (sy2 ^ sy3)) | (sy2 & ~(sy2 ^ sy3));
        end
    end

    // Control register; a hardware set wins over a software clear.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            write_collision_flag <= CTRL_RESET[WRITE_COLLISION_FLAG_BIT];
            ovf <= CTRL_RESET[OVF_BIT];
            en <= CTRL_RESET[EN_BIT];
            clock_polarity_select <= CTRL_RESET[CKP_BIT];
            mode <= CTRL_RESET[MODE_LSB +: 4];
        end
        else if (wr && hit_ctrl)
        begin
            write_collision_flag <= PWDATA[WRITE_COLLISION_FLAG_BIT] || set_write_collision_flag;
            ovf <= PWDATA[OVF_BIT] || set_ovf;
            en <= PWDATA[EN_BIT];
            clock_polarity_select <= PWDATA[CKP_BIT];
            mode <= PWDATA[MODE_LSB +: 4];
        end
        else
        begin
            write_collision_flag <= write_collision_flag || set_write_collision_flag;
            ovf <= ovf || set_ovf;
        end
    end

    // Receive buffer; an overflowing byte is dropped, the held one kept.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rx_hold <= 8'h00;
            buf_full <= 1'b0;
        end
        else
        begin
            if (rx_event && !set_ovf)
                rx_hold <= rx_data;
            buf_full <= rx_event || (buf_full && !buf_clear);
        end
    end

    // Read data is latched in the setup cycle.
    always_ff @(posedge CLK)
    begin
        if (RST)
            PRDATA <= 32'h00000000;
        else if (setup && !PWRITE)
            PRDATA <= hit_ctrl ? {24'h000000, ctrl_value} :
                      hit_buf ? {24'h000000, rx_hold} :
                      hit_stat ? {30'h00000000, l.busy, buf_full} : 32'h00000000;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            I2C_TX_START <= 1'b0;
            I2C_TX_DATA <= 8'h00;
        end
        else
        begin
            I2C_TX_START <= wr && hit_buf && i2c_master && I2C_BUS_IDLE;
            if (wr && hit_buf && i2c_any)
                I2C_TX_DATA <= PWDATA[7:0];
        end
    end

    assign l.start = wr && hit_buf && spi_master && !l.busy;
    assign l.load = wr && hit_buf && spi_slave && !l.busy;
    assign l.tx_byte = PWDATA[7:0];
    assign l.mode = mode;
    assign l.en = en;
    assign l.clock_polarity_select = clock_polarity_select;
    assign l.tick = TMR_TICK;
    assign l.sck_in = filt[0];
    assign l.sdi_in = filt[1];
    assign l.ss_n_in = filt[2];

    spc_shift_engine u_engine (
        .clk(CLK),
        .rst(RST),
        .l(l)
    );

    // Pins belong to the port only while it is enabled.
    assign PINS_OWNED = en;
    assign SCK_O = l.sck_out;
    assign SCK_OE = spi_master;
    assign SDO_O = l.sdo_out;
    assign SDO_OE = spi_master || (spi_slave && !(mode == SPC_SPI_SSEL && filt[2]));
    assign SS_GPIO_FREE = !(en && mode == SPC_SPI_SSEL);
    assign SCL_HOLD_LOW = en && spc_is_i2c_slave(mode) && !clock_polarity_select;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_buf_write;
        wr && hit_buf;
    endsequence

    sequence s_rx_while_full;
        rx_event && buf_full && !buf_clear;
    endsequence

    sequence s_idle_steady;
        (!l.busy && $stable(clock_polarity_select))[*3];
    endsequence

    AST_WRITE_COLLISION_FLAG_I2C: assert property (s_buf_write ##0 i2c_master && !I2C_BUS_IDLE |=> write_collision_flag)
        else $error("Collision flag not set on busy I2C bus.");
    AST_I2C_NO_START: assert property (s_buf_write ##0 !I2C_BUS_IDLE |=> !I2C_TX_START)
        else $error("I2C transmit started on a busy bus.");
    AST_OVF_SPI: assert property (s_rx_while_full ##0 spi_slave |=> ovf && rx_hold == $past(rx_hold))
        else $error("Slave overflow not flagged or buffer overwritten.");
    AST_NO_OVF_MASTER: assert property (spi_master && !ovf && !(wr && hit_ctrl) |=> !ovf)
        else $error("Overflow flag set in SPI master mode.");
    AST_MASTER_START: assert property ($rose(l.busy) && spi_master |-> $past(wr && hit_buf))
        else $error("Master transfer began without a buffer write.");
    AST_OVF_I2C: assert property (s_rx_while_full ##0 i2c_any |=> ovf)
        else $error("I2C overflow not flagged.");
    AST_OVF_STICKY: assert property (ovf && !(wr && hit_ctrl) |=> ovf)
        else $error("Overflow flag cleared without software.");
    AST_SS_IGNORED: assert property (en && mode == SPC_SPI_SFREE |-> SS_GPIO_FREE)
        else $error("Select pin not released in free-select mode.");
    AST_PINS_RELEASED: assert property (!en |-> !SCK_OE && !SDO_OE && !PINS_OWNED)
        else $error("Serial pins driven while port disabled.");
    AST_IDLE_LEVEL: assert property (spi_master ##0 s_idle_steady |-> SCK_O == clock_polarity_select)
        else $error("SPI clock idle level does not follow polarity.");
    AST_STRETCH: assert property ($fell(clock_polarity_select) && en && spc_is_i2c_slave(mode) |-> SCL_HOLD_LOW)
        else $error("I2C slave clock not held low.");
endmodule : spc_port_control
`default_nettype wire

/* File: test/spc_spi_peer.sv */
// Purpose: SPI peer on the far side of the serial pins.
// Assumes: Clock idles low; data changes on the falling edge.
// Notes: Slave to the device clock, or master once started.
`timescale 1ns/100ps
`default_nettype none
module spc_spi_peer (
    // Clock.
    input wire logic clk,
    // Pins from the device.
    input wire logic dut_sck,
    input wire logic dut_sdo,
    // Bench control.
    input wire logic load,
    input wire logic go,
    input wire logic [7:0] tx,
    // Pins to the device and results.
    output logic sck,
    output logic sdo,
    output logic busy,
    output logic [7:0] rx
);
    logic [7:0] sr = 8'h00;
    assign sdo = sr[7];
    initial
    begin
        sck = 1'b0;
        busy = 1'b0;
        rx = 8'h00;
    end
    always @(posedge clk)
    begin
        if (load)
            sr <= tx;
    end
    // Spent bits are refilled inverted so stale data never looks valid.
    always @(negedge dut_sck)
        sr <= {sr[6:0], ~sr[7]};
    always @(posedge dut_sck)
        rx <= {rx[6:0], dut_sdo};
    // Master frame: eight clocks per half period, which leaves room for the pin filter.
    always @(posedge clk)
    begin
        if (go)
        begin
            busy <= 1'b1;
            for (int i = 0; i < 8; i++)
            begin
                repeat (8) @(posedge clk);
                sck <= 1'b1;
                rx <= {rx[6:0], dut_sdo};
                repeat (8) @(posedge clk);
                sck <= 1'b0;
                sr <= {sr[6:0], ~sr[7]};
            end
            busy <= 1'b0;
        end
    end
endmodule : spc_spi_peer
`default_nettype wire

/* File: test/spc_port_control_tb.sv */
// Purpose: Self-checking bench for the serial port control block.
// Assumes: APB master waits for ready; the watchdog bounds every wait.
// Notes: Random data from a fixed seed.
`timescale 1ns/100ps
`default_nettype none
module spc_port_control_tb;
    import spc_pkg::*;
    localparam logic [7:0] A_CTRL = CTRL_INDEX << 2;
    localparam logic [7:0] A_BUF = BUF_INDEX << 2;
    localparam logic [7:0] A_STAT = STAT_INDEX << 2;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, SCK_I, SCK_O, SCK_OE, SDI_I, SDO_O, SDO_OE;
    logic SS_N_I = 1'b1;
    logic TMR_TICK = 1'b0;
    logic I2C_BUS_IDLE = 1'b0;
    logic I2C_RX_VALID = 1'b0;
    logic [7:0] I2C_RX_DATA = 8'h00;
    logic SS_GPIO_FREE, PINS_OWNED, I2C_TX_START, SCL_HOLD_LOW;
    logic [7:0] I2C_TX_DATA, ptx, prx, b1, b2;
    logic pload = 1'b0;
    logic pgo = 1'b0;
    logic pbusy, e;
    logic [31:0] q;
    int seed = 32'hc5b8;
    int bad_count = 0;
    int num_checks = 0;
    int starts = 0;
    spc_port_control DUT (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .SCK_I(SCK_I), .SCK_O(SCK_O),
        .SCK_OE(SCK_OE), .SDI_I(SDI_I), .SDO_O(SDO_O), .SDO_OE(SDO_OE),
        .SS_N_I(SS_N_I), .SS_GPIO_FREE(SS_GPIO_FREE), .PINS_OWNED(PINS_OWNED),
        .TMR_TICK(TMR_TICK), .I2C_BUS_IDLE(I2C_BUS_IDLE), .I2C_RX_VALID(I2C_RX_VALID),
        .I2C_RX_DATA(I2C_RX_DATA), .I2C_TX_START(I2C_TX_START),
        .I2C_TX_DATA(I2C_TX_DATA), .SCL_HOLD_LOW(SCL_HOLD_LOW));
    spc_spi_peer PEER (.clk(CLK), .dut_sck(SCK_O), .dut_sdo(SDO_O), .load(pload),
        .go(pgo), .tx(ptx), .sck(SCK_I), .sdo(SDI_I), .busy(pbusy), .rx(prx));
    always #20 CLK = ~CLK;
    always @(posedge CLK)
    begin
        TMR_TICK <= ($random(seed) % 4) == 0;
        if (I2C_TX_START === 1'b1)
            starts <= starts + 1;
    end
    function automatic logic [31:0] ex_ctl(input logic [7:0] v, input logic w, input logic o);
        return {24'h0, w, o, v[5:0]};
    endfunction : ex_ctl
    function automatic logic [3:0] ex_pins(input logic [7:0] v);
        return {v[5], ~(v[5] && v[3:0] == 4'h4), v[5] && !v[4] && v[3:1] == 3'b011,
            v[5] && v[3:0] < 4'h4};
    endfunction : ex_pins
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1)
            @(posedge CLK);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(q, exp);
    endtask : rdchk
    task automatic wait_idle();
        apb(1'b0, A_STAT, 32'h0);
        while (q[1] !== 1'b0)
            apb(1'b0, A_STAT, 32'h0);
    endtask : wait_idle
    task automatic peer(input logic [7:0] t, input logic g);
        ptx <= t;
        pload <= 1'b1;
        @(posedge CLK);
        pload <= 1'b0;
        pgo <= g;
        @(posedge CLK);
        pgo <= 1'b0;
        repeat (2) @(posedge CLK);
        while (pbusy === 1'b1)
            @(posedge CLK);
        repeat (8) @(posedge CLK);
    endtask : peer
    task automatic rx_byte(input logic [7:0] d);
        I2C_RX_DATA <= d;
        I2C_RX_VALID <= 1'b1;
        @(posedge CLK);
        I2C_RX_VALID <= 1'b0;
        @(posedge CLK);
    endtask : rx_byte
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (20000) @(posedge CLK);
        bad_count++;
        print_verdict();
    end
    initial
    begin
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        rdchk(A_CTRL, {24'h0, CTRL_RESET});
        check({PINS_OWNED, SS_GPIO_FREE, SCL_HOLD_LOW, SCK_OE}, ex_pins(8'h00));
        for (int m = 0; m < 9; m++)
        begin
            b1 = {3'b001, 1'($random(seed)), 4'(m)};
            apb(1'b1, A_CTRL, {24'($random(seed)), b1});
            rdchk(A_CTRL, ex_ctl(b1, 1'b0, 1'b0));
            check({PINS_OWNED, SS_GPIO_FREE, SCL_HOLD_LOW, SCK_OE}, ex_pins(b1));
            if (m < 4)
                check(SCK_O, b1[4]);
        end
        apb(1'b1, A_CTRL, 32'h0);
        check(PINS_OWNED, 1'b0);
        rdchk(8'h40, 32'h0);
        check(e, 1'b1);
        $display("test register done");
        b1 = 8'($random(seed));
        b2 = 8'($random(seed));
        peer(b2, 1'b0);
        apb(1'b1, A_CTRL, 32'h21);
        check(SCK_O, 1'b0);
        check({SCK_OE, SDO_OE}, 2'b11);
        apb(1'b1, A_BUF, {24'h0, b1});
        apb(1'b1, A_BUF, 32'hA5);
        wait_idle();
        rdchk(A_CTRL, ex_ctl(8'h21, 1'b1, 1'b0));
        check(prx, b1);
        rdchk(A_BUF, {24'h0, b2});
        apb(1'b1, A_CTRL, 32'h23);
        apb(1'b1, A_BUF, 32'h3C);
        wait_idle();
        apb(1'b1, A_BUF, 32'hC3);
        wait_idle();
        check(prx, 8'hC3);
        rdchk(A_CTRL, ex_ctl(8'h23, 1'b0, 1'b0));
        apb(1'b0, A_BUF, 32'h0);
        $display("test spi master done");
        apb(1'b1, A_CTRL, 32'h25);
        rdchk(A_CTRL, 32'h25);
        check({SCK_OE, SDO_OE}, 2'b01);
        b1 = 8'($random(seed));
        b2 = 8'($random(seed));
        apb(1'b1, A_BUF, {24'h0, b1});
        peer(b2, 1'b1);
        check(prx, b1);
        rdchk(A_BUF, {24'h0, b2});
        peer(8'h5A, 1'b1);
        peer(8'h96, 1'b1);
        rdchk(A_CTRL, ex_ctl(8'h25, 1'b0, 1'b1));
        rdchk(A_BUF, 32'h5A);
        $display("test spi slave done");
        apb(1'b1, A_CTRL, 32'h28);
        apb(1'b1, A_BUF, 32'h11);
        rdchk(A_CTRL, ex_ctl(8'h28, 1'b1, 1'b0));
        check(starts, 0);
        apb(1'b1, A_CTRL, 32'h28);
        I2C_BUS_IDLE <= 1'b1;
        b1 = 8'($random(seed));
        apb(1'b1, A_BUF, {24'h0, b1});
        rdchk(A_CTRL, 32'h28);
        check(starts, 1);
        check(I2C_TX_DATA, b1);
        $display("test i2c master done");
        apb(1'b0, A_BUF, 32'h0);
        apb(1'b1, A_CTRL, 32'h36);
        check(SCL_HOLD_LOW, 1'b0);
        b1 = 8'($random(seed));
        rx_byte(b1);
        rx_byte(8'($random(seed)));
        rdchk(A_CTRL, ex_ctl(8'h36, 1'b0, 1'b1));
        rdchk(A_BUF, {24'h0, b1});
        rdchk(A_CTRL, ex_ctl(8'h36, 1'b0, 1'b1));
        apb(1'b1, A_CTRL, 32'h36);
        rdchk(A_CTRL, 32'h36);
        $display("test i2c slave done");
        print_verdict();
    end
endmodule : spc_port_control_tb
`default_nettype wire
